// ### src/mcfc_top.sv
// Summary of operation
// - Accepting start clears start request and done, then runs both timers.
// - Each reference divider match captures the measurement count, raising a capture event.
// - First capture after start is discarded; flags untouched, counting goes on.
// - Second capture becomes the result and stops both timers.
// - After judging, the error flag is updated, then done is set.
// - Reference divider spans 512 sub-clock rising edges per period.
// - Lower window limit is the constant count 42187.
// - Upper window limit is the constant count 51562.
// - Error flag: 0 for normal frequency, 1 for abnormal.
// - Done flag is 0 before and during measurement, 1 when finished.
// - Normal only when result lies inclusively within both limits.
// - Measurement timer counts peripheral clock divided by 16.
// - Reference divider counts sub-clock edges, clears on match at ratio minus one.
// - Measurement counter clears on every capture, one period per capture.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "mcfc_defines.svh"
module mcfc_top
  import mcfc_pkg::*;
#(
  parameter int REF_DIV = `MCFC_REF_DIV,
  parameter int PRESCALE = `MCFC_PRESCALE,
  parameter int MEAS_W = 16,
  parameter int CAPCNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sub_clk_in,
  output mcfc_status_t status,
  output logic [MEAS_W-1:0] result
);

  localparam int REF_W = $clog2(REF_DIV);
  localparam int PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [REF_W-1:0] REF_CMP = REF_W'(REF_DIV - 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);
  localparam logic [MEAS_W-1:0] MEAS_MAX = {MEAS_W{1'b1}};
  localparam logic [CAPCNT_W-1:0] CAPCNT_MAX = {CAPCNT_W{1'b1}};
  localparam logic [MEAS_W-1:0] LIMIT_LOW = MEAS_W'(`MCFC_LIMIT_LOW);
  localparam logic [MEAS_W-1:0] LIMIT_HIGH = MEAS_W'(`MCFC_LIMIT_HIGH);

  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
    addr_is = (addr == off);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = addr_is(addr, `MCFC_OFF_CTRL) || addr_is(addr, `MCFC_OFF_STATUS) ||
                  addr_is(addr, `MCFC_OFF_RESULT) || addr_is(addr, `MCFC_OFF_CAPCNT) ||
                  addr_is(addr, `MCFC_OFF_LIVE) || addr_is(addr, `MCFC_OFF_REFCNT) ||
                  addr_is(addr, `MCFC_OFF_LIMITS) || addr_is(addr, `MCFC_OFF_CAPTURE);
  endfunction

  function automatic logic in_window(input logic [MEAS_W-1:0] value);
    in_window = (value >= LIMIT_LOW) && (value <= LIMIT_HIGH);
  endfunction

  mcfc_state_t state;
  mcfc_state_t next_state;

  logic sub_rise;
  logic running;
  logic accept;
  logic ref_match;
  logic tick;
  logic apb_setup;
  logic apb_write;
  logic start_wr;

  logic start_pending;
  logic done;
  logic freq_err;
  logic [REF_W-1:0] ref_cnt;
  logic [PRE_W-1:0] pre_cnt;
  logic [MEAS_W-1:0] meas_cnt;
  logic [MEAS_W-1:0] capture;
  logic [CAPCNT_W-1:0] capture_event_counter;
  logic [31:0] next_rdata;

  // Sub-clock comes from a pin: synchronised before any use
  mcfc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sub_clk_in),
    .rise(sub_rise)
  );

  assign running = (state == MCFC_ST_FIRST) || (state == MCFC_ST_SECOND);
  // a new run only begins from idle
  assign accept = (state == MCFC_ST_IDLE) && start_pending;

  // APB decode
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  // a written 1 requests a start, a 0 does nothing
  assign start_wr = apb_write && addr_is(paddr, `MCFC_OFF_CTRL) && pstrb[0] &&
                    pwdata[`MCFC_CTRL_START_BIT];
  assign pready = 1'b1;

  // compare match at ratio minus one
  assign ref_match = running && sub_rise && (ref_cnt == REF_CMP);
  // one count per sixteen peripheral clocks
  assign tick = running && (pre_cnt == PRE_LAST);

  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      MCFC_ST_IDLE: begin
        if (accept) begin
          next_state = MCFC_ST_FIRST;
        end
      end
      MCFC_ST_FIRST: begin
        // first capture is only a warm-up
        if (ref_match) begin
          next_state = MCFC_ST_SECOND;
        end
      end
      MCFC_ST_SECOND: begin
        if (ref_match) begin
          next_state = MCFC_ST_JUDGE;
        end
      end
      MCFC_ST_JUDGE: begin
        next_state = MCFC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MCFC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Start request: a new write wins over the clear on accept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pending <= `MCFC_RST_FLAG;
    end else if (start_wr) begin
      start_pending <= 1'b1;
    end else if (accept) begin
      start_pending <= 1'b0;
    end
  end

  // Reference divider timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= '0;
    end else if (accept) begin
      ref_cnt <= '0;
    end else if (running && sub_rise) begin
      if (ref_match) begin
        ref_cnt <= '0;
      end else begin
        ref_cnt <= ref_cnt + REF_W'(1);
      end
    end
  end

  // Peripheral clock prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= '0;
    end else if (accept) begin
      pre_cnt <= '0;
    end else if (running) begin
      if (tick) begin
        pre_cnt <= '0;
      end else begin
        pre_cnt <= pre_cnt + PRE_W'(1);
      end
    end
  end

  // Measurement timer, saturating so a slow oscillator still reads out of window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_cnt <= '0;
    end else if (accept) begin
      meas_cnt <= '0;
    end else if (running) begin
      if (ref_match) begin
        // clear on capture, keeping a coincident tick
        meas_cnt <= tick ? MEAS_W'(1) : '0;
      end else if (tick && (meas_cnt != MEAS_MAX)) begin
        meas_cnt <= meas_cnt + MEAS_W'(1);
      end
    end
  end

  // Capture register and capture event count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture <= '0;
    end else if (ref_match) begin
      capture <= meas_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_event_counter <= '0;
    end else if (accept) begin
      capture_event_counter <= '0;
    end else if (ref_match && (capture_event_counter != CAPCNT_MAX)) begin
      capture_event_counter <= capture_event_counter + CAPCNT_W'(1);
    end
  end

  // Result and error flag, updated on the second capture only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= '0;
    end else if ((state == MCFC_ST_SECOND) && ref_match) begin
      result <= meas_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_err <= `MCFC_RST_FLAG;
    end else if ((state == MCFC_ST_SECOND) && ref_match) begin
      // 1 means abnormal, and bound the window
      freq_err <= !in_window(meas_cnt);
    end
  end

  // Done flag follows the error update by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= `MCFC_RST_FLAG;
    end else if (accept) begin
      done <= 1'b0;
    end else if (state == MCFC_ST_JUDGE) begin
      done <= 1'b1;
    end
  end

  assign status.pending = start_pending;
  assign status.busy = (state != MCFC_ST_IDLE);
  assign status.err = freq_err;
  assign status.done = done;

  // Read data mux
  always_comb begin
    next_rdata = `MCFC_RST_WORD;
    if (addr_is(paddr, `MCFC_OFF_CTRL)) begin
      next_rdata[`MCFC_CTRL_START_BIT] = start_pending;
    end else if (addr_is(paddr, `MCFC_OFF_STATUS)) begin
      next_rdata[`MCFC_STAT_DONE_BIT] = done;
      next_rdata[`MCFC_STAT_ERR_BIT] = freq_err;
      next_rdata[`MCFC_STAT_BUSY_BIT] = status.busy;
      next_rdata[`MCFC_STAT_PEND_BIT] = start_pending;
    end else if (addr_is(paddr, `MCFC_OFF_RESULT)) begin
      next_rdata[MEAS_W-1:0] = result;
    end else if (addr_is(paddr, `MCFC_OFF_CAPCNT)) begin
      next_rdata[CAPCNT_W-1:0] = capture_event_counter;
    end else if (addr_is(paddr, `MCFC_OFF_LIVE)) begin
      next_rdata[MEAS_W-1:0] = meas_cnt;
    end else if (addr_is(paddr, `MCFC_OFF_REFCNT)) begin
      next_rdata[REF_W-1:0] = ref_cnt;
    end else if (addr_is(paddr, `MCFC_OFF_LIMITS)) begin
      next_rdata[`MCFC_LIMITS_LOW_LSB +: MEAS_W] = LIMIT_LOW;
      next_rdata[`MCFC_LIMITS_HIGH_LSB +: MEAS_W] = LIMIT_HIGH;
    end else if (addr_is(paddr, `MCFC_OFF_CAPTURE)) begin
      next_rdata[MEAS_W-1:0] = capture;
    end
  end

  // Read data and error are latched in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `MCFC_RST_WORD;
    end else if (apb_setup) begin
      prdata <= pwrite ? `MCFC_RST_WORD : next_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= !addr_mapped(paddr);
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule

// ### common/mcfc_defines.svh
`ifndef MCFC_DEFINES_SVH
`define MCFC_DEFINES_SVH

// Register byte offsets on the APB
`define MCFC_OFF_CTRL 12'h000
`define MCFC_OFF_STATUS 12'h004
`define MCFC_OFF_RESULT 12'h008
`define MCFC_OFF_CAPCNT 12'h00c
`define MCFC_OFF_LIVE 12'h010
`define MCFC_OFF_REFCNT 12'h014
`define MCFC_OFF_LIMITS 12'h018
`define MCFC_OFF_CAPTURE 12'h01c

// Field positions
`define MCFC_CTRL_START_BIT 0
`define MCFC_STAT_DONE_BIT 0
`define MCFC_STAT_ERR_BIT 1
`define MCFC_STAT_BUSY_BIT 2
`define MCFC_STAT_PEND_BIT 3
`define MCFC_LIMITS_LOW_LSB 0
`define MCFC_LIMITS_HIGH_LSB 16

// Reset values
`define MCFC_RST_WORD 32'h0000_0000
`define MCFC_RST_FLAG 1'b0

// Measurement constants
`define MCFC_REF_DIV 512
`define MCFC_PRESCALE 16
// Lower limit 42187, upper limit 51562
`define MCFC_LIMIT_LOW 16'ha4cb
`define MCFC_LIMIT_HIGH 16'hc96a

`endif

// ### common/mcfc_pkg.sv
package mcfc_pkg;

  typedef enum logic [1:0] {
    MCFC_ST_IDLE,
    MCFC_ST_FIRST,
    MCFC_ST_SECOND,
    MCFC_ST_JUDGE
  } mcfc_state_t;

  typedef struct packed {
    logic pending;
    logic busy;
    logic err;
    logic done;
  } mcfc_status_t;

endpackage

// ### src/mcfc_sync.sv
`timescale 1ns/1ps
module mcfc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic rise
);

  logic meta;
  logic stable;
  logic stable_d;

  // Two-stage synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      stable <= 1'b0;
      stable_d <= 1'b0;
    end else begin
      meta <= async_in;
      stable <= meta;
      stable_d <= stable;
    end
  end

  assign rise = stable & ~stable_d;

endmodule

// ### testbench/mcfc_monitor.sv
`timescale 1ns/1ps
module mcfc_monitor
  import mcfc_pkg::*;
#(
  parameter int MEAS_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire mcfc_status_t status,
  input wire logic [MEAS_W-1:0] result
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_done_idle;
    status.done |-> !status.busy;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while busy");
  property p_accept;
    $rose(status.busy) |-> $past(status.pending) && !status.done;
  endproperty
  a_accept: assert property (p_accept) else $error("bad accept");
  property p_done_rise;
    $rose(status.done) |-> $past(status.busy) && $stable(status.err) && $stable(result);
  endproperty
  a_done_rise: assert property (p_done_rise) else $error("done before judge");
  property p_judge;
    $rose(status.done) |-> status.err == (result < 42187 || result > 51562);
  endproperty
  a_judge: assert property (p_judge) else $error("wrong judgement");
  property p_hold;
    status.done && !status.pending |=> status.done;
  endproperty
  a_hold: assert property (p_hold) else $error("done lost while idle");
  property p_result_busy;
    !$stable(result) |-> $past(status.busy);
  endproperty
  a_result_busy: assert property (p_result_busy) else $error("result moved while idle");
  property p_start_sets;
    psel && penable && pwrite && paddr == 12'h000 && pstrb[0] && pwdata[0] |=> status.pending;
  endproperty
  a_start_sets: assert property (p_start_sets) else $error("start not pending");
  property p_first;
    $rose(status.busy) |-> status.busy [*4];
  endproperty
  a_first: assert property (p_first) else $error("run ended too soon");
endmodule

bind mcfc_top mcfc_monitor #(.MEAS_W(MEAS_W)) u_mcfc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .status(status),
  .result(result));

// ### testbench/mcfc_sub_osc.sv
`timescale 1ns/1ps
module mcfc_sub_osc (
  input wire logic [31:0] half_ns,
  output logic sub_clk
);
  initial begin
    sub_clk = 1'b0;
    #1;
    forever #(half_ns) sub_clk = ~sub_clk;
  end
endmodule

// ### testbench/mcfc_top_tb.sv
`timescale 1ns/1ps
module mcfc_top_tb;
  import mcfc_pkg::*;
  localparam int RD = 2;
  localparam int PS = 2;
  localparam logic [44:0] ROWS [10] = '{{12'h000, 32'h0, 1'b0}, {12'h004, 32'h0, 1'b0},
    {12'h008, 32'h0, 1'b0}, {12'h00c, 32'h0, 1'b0}, {12'h018, 32'hc96aa4cb, 1'b0},
    {12'h020, 32'h0, 1'b1}, {12'hffc, 32'h0, 1'b1}, {12'h010, 32'h0, 1'b0},
    {12'h014, 32'h0, 1'b0}, {12'h01c, 32'h0, 1'b0}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] half = 32'd2000;
  logic [31:0] prdata, q, y, z;
  logic pready, pslverr, sub_clk, e;
  mcfc_status_t status;
  logic [15:0] result;
  int x;
  int mismatches = 0;
  int check_count = 0;
  always #50 pclk = ~pclk;
  mcfc_top #(.REF_DIV(RD), .PRESCALE(PS)) u_mcfc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sub_clk_in(sub_clk), .status(status), .result(result));
  mcfc_sub_osc u_mcfc_sub_osc (.half_ns(half), .sub_clk(sub_clk));
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] xp, input logic [31:0] got);
    check_count++;
    if (got !== xp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, xp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        results();
      end
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input logic [11:0] a, input int lim);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0);
    while (q[7:0] === 8'h00 && n < lim) begin
      n++;
      apb(1'b0, a, 32'h0);
    end
    if (q[7:0] === 8'h00) begin
      mismatches++;
      results();
    end
  endtask
  task automatic wdone(input int lim);
    int n;
    n = 0;
    @(posedge pclk);
    while (status.done !== 1'b1 && n < lim) begin
      n++;
      @(posedge pclk);
    end
    if (status.done !== 1'b1) begin
      mismatches++;
      results();
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      apb(1'b0, ROWS[i][44:33], 32'h0);
      chk("reg", ROWS[i][32:1], q);
      chk("slverr", {31'h0, ROWS[i][0]}, {31'h0, e});
    end
    apb(1'b1, 12'h000, 32'h1);
    poll(12'h00c, 500);
    chk("first_status", 32'h4, {28'h0, status});
    chk("first_result", 32'h0, {16'h0, result});
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("pending", 32'hc, q);
    x = RD * 2 * 2000 / (100 * PS);
    for (int r = 0; r < 2; r++) begin
      wdone(3000);
      chk("err_high", 32'h1, {31'h0, status.err});
      chk("result_fast", 32'h1, {31'h0, result >= x - 2 && result <= x + 2});
      repeat (2) @(posedge pclk);
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk("capcnt", 32'h2, q);
    apb(1'b0, 12'h01c, 32'h0);
    chk("capture", 32'h1, {31'h0, q >= x - 2 && q <= x + 2});
    apb(1'b0, 12'h014, 32'h0);
    y = q;
    apb(1'b0, 12'h010, 32'h0);
    z = q;
    repeat (100) @(posedge pclk);
    apb(1'b0, 12'h014, 32'h0);
    chk("idle_ref", y, q);
    apb(1'b0, 12'h010, 32'h0);
    chk("idle_live", z, q);
    apb(1'b0, 12'h004, 32'h0);
    chk("idle_status", 32'h3, q);
    pstrb <= 4'h0;
    apb(1'b1, 12'h000, 32'h1);
    pstrb <= 4'hf;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    chk("ro_slverr", 32'h0, {31'h0, e});
    apb(1'b0, 12'h004, 32'h0);
    chk("no_start", 32'h3, q);
    apb(1'b1, 12'h000, 32'h1);
    repeat (30) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("reset_status", 32'h0, q);
    apb(1'b1, 12'h000, 32'h1);
    poll(12'h00c, 500);
    half <= 32'd3124000;
    x = (2000 + 3 * 3124000) / (100 * PS);
    wdone(100000);
    chk("err_low", 32'h0, {31'h0, status.err});
    chk("result_ok", 32'h1, {31'h0, result >= x - 2 && result <= x + 2});
    results();
  end
endmodule
